/* File: src/power_mode_reset_input_mux.sv */
// Power mode sequencing, reset handling, register port and channel drive of the relay switch.
//
// Local design decisions: the address map and strobed register access.
module power_mode_reset_input_mux #(
	parameter int WAKE_TIME_CYCLES = power_mode_pkg::WAKE_CYCLES
) (
	input wire logic REF_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic BATTERY_SUPPLY_OK_IN,
	input wire logic LOGIC_SUPPLY_OK_IN,
	input wire logic INPUT_PIN_FIRST_IN,
	input wire logic INPUT_PIN_SECOND_IN,
	input wire logic INPUT_PIN_THIRD_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	input wire logic REG_WRITE_IN,
	input wire logic REG_READ_IN,
	output logic [31:0] REG_RDATA_OUT,
	output logic [7:0] CHANNEL_OUT,
	output logic OPERATION_MODE_OUT,
	output logic IRQ_OUT
);

	// ==========================================================
	// Elaboration check.
	if (WAKE_TIME_CYCLES < 1) begin : g_bad_wake
		$error("WAKE_TIME_CYCLES must be at least one");
	end

	// ==========================================================
	// Declarations.
	power_mode_pkg::mode_t state, next_state;
	logic [31:0] wake_count, next_wake_count;
	logic [15:0] input_select, next_input_select;
	logic [7:0] alt_pin, next_alt_pin;
	logic tef, next_tef;
	logic uv_prev, next_uv_prev;
	logic [2:0] irq_status, next_irq_status;
	logic [2:0] irq_mask, next_irq_mask;
	logic [31:0] next_rdata;
	logic [7:0] next_channel;
	logic next_irq;
	logic next_operation;
	logic [4:0] pins_sync;
	logic battery_ok, logic_ok;
	logic [2:0] input_pins;
	logic [7:0] demand;
	logic uv_active;
	logic cmd_write, wake_cmd, standby_cmd, reset_cmd;
	logic [31:0] status_word;
	logic [2:0] irq_events;

	// ==========================================================
	// Pins from outside the clock domain pass two flip-flops first.
	level_sync #(
		.WIDTH(5)
	) u_sync (
		.clk_in(REF_CLK_IN),
		.reset_n_in(RESET_N_IN),
		.async_in({INPUT_PIN_THIRD_IN, INPUT_PIN_SECOND_IN, INPUT_PIN_FIRST_IN,
			LOGIC_SUPPLY_OK_IN, BATTERY_SUPPLY_OK_IN}),
		.sync_out(pins_sync)
	);

	assign battery_ok = pins_sync[0];
	assign logic_ok = pins_sync[1];
	assign input_pins = pins_sync[4:2];

	channel_input_mux #(
		.CHANNELS(power_mode_pkg::CHANNELS)
	) u_mux (
		.select_in(input_select),
		.alt_pin_in(alt_pin),
		.pin_in(input_pins),
		.demand_out(demand)
	);

	// ==========================================================
	// Reset sources and command decode.
	// Undervoltage holds while either supply is low; a lost logic supply also drops into sleep.
	assign uv_active = !battery_ok || !logic_ok;
	// Writes are ignored while undervoltage holds, because the banks are held at default.
	assign cmd_write = REG_WRITE_IN && (REG_ADDR_IN == power_mode_pkg::ADDR_COMMAND) && !uv_active;
	assign reset_cmd = cmd_write && REG_WDATA_IN[power_mode_pkg::CMD_RESET_BIT];
	assign standby_cmd = cmd_write && REG_WDATA_IN[power_mode_pkg::CMD_STANDBY_BIT];
	assign wake_cmd = cmd_write && REG_WDATA_IN[power_mode_pkg::CMD_WAKE_BIT];

	always_comb begin
		status_word = '0;
		status_word[power_mode_pkg::STATUS_OPERATE_BIT] = (state == power_mode_pkg::MODE_OPERATE);
		status_word[power_mode_pkg::STATUS_TEF_BIT] = tef;
		status_word[power_mode_pkg::STATUS_UV_BIT] = uv_active;
		status_word[power_mode_pkg::STATUS_WAKING_BIT] = (state == power_mode_pkg::MODE_WAKING);
	end

	// ==========================================================
	// Mode sequencing: sleep, waking delay, operation.
	always_comb begin
		next_state = state;
		next_wake_count = wake_count;
		case (state)
			power_mode_pkg::MODE_SLEEP: begin
				if (wake_cmd && !standby_cmd && !reset_cmd) begin
					next_state = power_mode_pkg::MODE_WAKING;
					next_wake_count = '0;
				end
			end
			power_mode_pkg::MODE_WAKING: begin
				// The wake delay ends at its upper bound, so the host's wait always covers it.
				if (wake_count == 32'(WAKE_TIME_CYCLES - 1)) begin
					next_state = power_mode_pkg::MODE_OPERATE;
				end else begin
					next_wake_count = wake_count + 32'h0000_0001;
				end
			end
			power_mode_pkg::MODE_OPERATE: begin
				next_state = power_mode_pkg::MODE_OPERATE;
			end
			default: next_state = power_mode_pkg::MODE_SLEEP;
		endcase
		// Resets and standby override any wake in progress.
		if (uv_active || reset_cmd || standby_cmd) begin
			next_state = power_mode_pkg::MODE_SLEEP;
			next_wake_count = '0;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state <= power_mode_pkg::MODE_SLEEP;
			wake_count <= '0;
		end else begin
			state <= next_state;
			wake_count <= next_wake_count;
		end
	end

	// ==========================================================
	// Register banks, transfer error flag and interrupt state.
	always_comb begin
		next_input_select = input_select;
		next_alt_pin = alt_pin;
		next_irq_mask = irq_mask;
		next_tef = tef;
		next_irq_status = irq_status;
		next_uv_prev = uv_active;
		irq_events = '0;
		if (REG_WRITE_IN && !uv_active) begin
			if (REG_ADDR_IN == power_mode_pkg::ADDR_INPUT_SELECT) begin
				next_input_select = REG_WDATA_IN[15:0];
			end
			if (REG_ADDR_IN == power_mode_pkg::ADDR_ALT_PIN) begin
				next_alt_pin = REG_WDATA_IN[7:0];
			end
			if (REG_ADDR_IN == power_mode_pkg::ADDR_IRQ_MASK) begin
				next_irq_mask = REG_WDATA_IN[2:0];
			end
		end
		// Read-to-clear comes first so that a same-cycle event still sets its bit.
		if (REG_READ_IN && (REG_ADDR_IN == power_mode_pkg::ADDR_STATUS) && !uv_active) begin
			next_tef = 1'b0;
		end
		// A read during undervoltage returns the frame, so it must not clear events it never showed.
		if (REG_READ_IN && (REG_ADDR_IN == power_mode_pkg::ADDR_IRQ_STATUS) && !uv_active) begin
			next_irq_status = '0;
		end
		// Select and pin banks reset on undervoltage, reset command or standby command; the mask on the first two only.
		if (uv_active || reset_cmd || standby_cmd) begin
			next_input_select = power_mode_pkg::INPUT_SELECT_RESET;
			next_alt_pin = power_mode_pkg::ALT_PIN_RESET;
		end
		if (uv_active || reset_cmd) begin
			next_irq_mask = power_mode_pkg::IRQ_MASK_RESET;
		end
		// The flag marks every completed reset: command at once, undervoltage on release.
		if (reset_cmd || (uv_prev && !uv_active)) begin
			next_tef = 1'b1;
			irq_events[power_mode_pkg::IRQ_RESET_DONE_BIT] = 1'b1;
		end
		if (uv_active) begin
			next_tef = 1'b1;
		end
		irq_events[power_mode_pkg::IRQ_UV_BIT] = uv_active && !uv_prev;
		irq_events[power_mode_pkg::IRQ_AWAKE_BIT] = (state == power_mode_pkg::MODE_WAKING)
			&& (next_state == power_mode_pkg::MODE_OPERATE);
		next_irq_status = next_irq_status | irq_events;
	end

	// The reset values mark power-on: flag set and undervoltage assumed until supplies prove good.
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			input_select <= power_mode_pkg::INPUT_SELECT_RESET;
			alt_pin <= power_mode_pkg::ALT_PIN_RESET;
			irq_mask <= power_mode_pkg::IRQ_MASK_RESET;
			tef <= 1'b1;
			uv_prev <= 1'b1;
			irq_status <= '0;
		end else begin
			input_select <= next_input_select;
			alt_pin <= next_alt_pin;
			irq_mask <= next_irq_mask;
			tef <= next_tef;
			uv_prev <= next_uv_prev;
			irq_status <= next_irq_status;
		end
	end

	// ==========================================================
	// Outputs: read data, channel drive, mode and interrupt, all registered.
	always_comb begin
		next_rdata = '0;
		if (REG_READ_IN) begin
			if (uv_active) begin
				next_rdata = power_mode_pkg::DIAG_FRAME;
			end else begin
				case (REG_ADDR_IN)
					power_mode_pkg::ADDR_STATUS: next_rdata = status_word;
					power_mode_pkg::ADDR_INPUT_SELECT: next_rdata = {16'h0000, input_select};
					power_mode_pkg::ADDR_ALT_PIN: next_rdata = {24'h00_0000, alt_pin};
					power_mode_pkg::ADDR_IRQ_STATUS: next_rdata = {29'h0000_0000, irq_status};
					power_mode_pkg::ADDR_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
					default: next_rdata = '0;
				endcase
			end
		end
		// Channels drive only in operation mode; every other mode holds them off.
		next_channel = (state == power_mode_pkg::MODE_OPERATE) ? demand : 8'h00;
		next_operation = (state == power_mode_pkg::MODE_OPERATE);
		next_irq = |(irq_status & irq_mask);
	end

	// The read port lives on the logic supply, so it answers in every mode.
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			REG_RDATA_OUT <= '0;
			CHANNEL_OUT <= '0;
			OPERATION_MODE_OUT <= 1'b0;
			IRQ_OUT <= 1'b0;
		end else begin
			REG_RDATA_OUT <= next_rdata;
			CHANNEL_OUT <= next_channel;
			OPERATION_MODE_OUT <= next_operation;
			IRQ_OUT <= next_irq;
		end
	end

	// ==========================================================
	// Assertions.
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	sequence seq_wake_write;
		wake_cmd && !standby_cmd && !reset_cmd && (state == power_mode_pkg::MODE_SLEEP);
	endsequence

	sequence seq_wake_done;
		(state == power_mode_pkg::MODE_WAKING) && (wake_count == 32'(WAKE_TIME_CYCLES - 1)) && !uv_active
			&& !cmd_write;
	endsequence

	sequence seq_select_write;
		REG_WRITE_IN && (REG_ADDR_IN == power_mode_pkg::ADDR_INPUT_SELECT) && !uv_active;
	endsequence

	AST_UV_HOLDS_SLEEP: assert property (uv_active |=> (state == power_mode_pkg::MODE_SLEEP)
		&& (input_select == power_mode_pkg::INPUT_SELECT_RESET) ##1 (CHANNEL_OUT == 8'h00))
		else $error("Undervoltage did not force sleep and defaults");
	AST_UV_READ_DIAG: assert property (REG_READ_IN && uv_active
		|=> REG_RDATA_OUT == power_mode_pkg::DIAG_FRAME)
		else $error("Read during undervoltage did not return the diagnostic frame");
	AST_RESET_CMD: assert property (reset_cmd |=> (input_select == power_mode_pkg::INPUT_SELECT_RESET)
		&& tef && (state == power_mode_pkg::MODE_SLEEP))
		else $error("Reset command did not clear the banks");
	AST_TEF_RELEASE: assert property (uv_prev && !uv_active |=> tef)
		else $error("Transfer error flag not set after undervoltage release");
	AST_WAKE_ENTERS: assert property (seq_wake_write |=> (state == power_mode_pkg::MODE_WAKING)
		&& (wake_count == 32'h0000_0000))
		else $error("Wake command did not start the wake delay");
	AST_WAKE_BOUND: assert property (seq_wake_done |=> (state == power_mode_pkg::MODE_OPERATE)
		##1 OPERATION_MODE_OUT)
		else $error("Device not operational at the end of the wake delay");
	AST_STANDBY: assert property (standby_cmd |=> (state == power_mode_pkg::MODE_SLEEP)
		&& (input_select == power_mode_pkg::INPUT_SELECT_RESET) ##1 !OPERATION_MODE_OUT)
		else $error("Standby command did not enter sleep with banks reset");
	AST_OFF_UNLESS_OPERATE: assert property (state != power_mode_pkg::MODE_OPERATE |=> CHANNEL_OUT == 8'h00)
		else $error("Channel driven outside operation mode");
	AST_CHANNEL_FOLLOWS: assert property (state == power_mode_pkg::MODE_OPERATE
		|=> CHANNEL_OUT == $past(demand))
		else $error("Channel does not follow its selected source");
	AST_READ_ONE_CYCLE: assert property (!REG_READ_IN |=> REG_RDATA_OUT == 32'h0000_0000)
		else $error("Read data present without a read");

	// Guards on the banks, the error flag, the reset event and the wake counter.
	AST_SELECT_WRITE: assert property (seq_select_write
		|=> {16'h0000, input_select} == ($past(REG_WDATA_IN) & 32'h0000_FFFF))
		else $error("Input select write did not land");
	AST_UV_DEFAULTS: assert property (uv_active |=> (alt_pin == power_mode_pkg::ALT_PIN_RESET)
		&& (irq_mask == power_mode_pkg::IRQ_MASK_RESET))
		else $error("Undervoltage did not restore bank defaults");
	AST_TEF_DURING_UV: assert property (uv_active |=> tef)
		else $error("Transfer error flag clear during undervoltage");
	AST_RESET_DONE_IRQ: assert property (reset_cmd |=> irq_status[power_mode_pkg::IRQ_RESET_DONE_BIT])
		else $error("Reset command did not record its reset event");
	AST_WAKE_COUNT: assert property ((state == power_mode_pkg::MODE_WAKING) && !uv_active && !cmd_write
		&& (wake_count != 32'(WAKE_TIME_CYCLES - 1)) |=> (state == power_mode_pkg::MODE_WAKING)
		&& (wake_count == $past(wake_count) + 32'h0000_0001))
		else $error("Wake counter did not advance");

endmodule // power_mode_reset_input_mux

/* File: src/power_mode_pkg.sv */
// Constants, register map and mode encoding for the power mode, reset and input multiplexer block.
package power_mode_pkg;

	// ==========================================================
	// Sizes.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CHANNELS = 8;
	localparam int PIN_COUNT = 3;
	localparam int IRQ_W = 3;

	// ==========================================================
	// Register offsets (byte addresses, one word each).
	localparam logic [7:0] ADDR_COMMAND = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_INPUT_SELECT = 8'h08;
	localparam logic [7:0] ADDR_ALT_PIN = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

	// ==========================================================
	// Field positions.
	localparam int CMD_WAKE_BIT = 0;
	localparam int CMD_STANDBY_BIT = 1;
	localparam int CMD_RESET_BIT = 2;
	localparam int STATUS_OPERATE_BIT = 0;
	localparam int STATUS_TEF_BIT = 1;
	localparam int STATUS_UV_BIT = 2;
	localparam int STATUS_WAKING_BIT = 3;
	localparam int IRQ_RESET_DONE_BIT = 0;
	localparam int IRQ_AWAKE_BIT = 1;
	localparam int IRQ_UV_BIT = 2;

	// ==========================================================
	// Input select codes, two bits per channel.
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_FIRST = 2'h1;
	localparam logic [1:0] SEL_SECOND_THIRD = 2'h2;
	localparam logic [1:0] SEL_ON = 2'h3;

	// ==========================================================
	// Reset values.
	localparam logic [15:0] INPUT_SELECT_RESET = 16'h0000;
	localparam logic [7:0] ALT_PIN_RESET = 8'h00;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
	localparam logic [31:0] DIAG_FRAME = 32'h0000_0006;

	// ==========================================================
	// Timing: longest wake time, an exact whole number of cycles.
	localparam int CLK_MHZ = 100;
	localparam int WAKE_TIME_US = 200;
	localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;

	// ==========================================================
	// Power mode states, one-hot.
	typedef enum logic [2:0] {
		MODE_SLEEP = 3'h1,
		MODE_WAKING = 3'h2,
		MODE_OPERATE = 3'h4
	} mode_t;

endpackage

/* File: src/level_sync.sv */
// Two flip-flop synchroniser for asynchronous pin levels.
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	// ==========================================================
	// The first stage feeds only the second, which keeps metastability contained.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stage_one <= '0;
			sync_out <= '0;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule // level_sync

/* File: src/channel_input_mux.sv */
// Per-channel source multiplexer between fixed states and the control input pins.
module channel_input_mux #(
	parameter int CHANNELS = 8
) (
	input wire logic [2*CHANNELS-1:0] select_in,
	input wire logic [CHANNELS-1:0] alt_pin_in,
	input wire logic [power_mode_pkg::PIN_COUNT-1:0] pin_in,
	output logic [CHANNELS-1:0] demand_out
);

	// ==========================================================
	// One independent selector per channel.
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_channel
		always_comb begin
			case (select_in[2*ch +: 2])
				power_mode_pkg::SEL_OFF: demand_out[ch] = 1'b0;
				// A high pin is an on command, a low pin (also an open one) an off command.
				power_mode_pkg::SEL_FIRST: demand_out[ch] = pin_in[0];
				power_mode_pkg::SEL_SECOND_THIRD: demand_out[ch] = alt_pin_in[ch] ? pin_in[2] : pin_in[1];
				power_mode_pkg::SEL_ON: demand_out[ch] = 1'b1;
				default: demand_out[ch] = 1'b0;
			endcase
		end
	end

endmodule // channel_input_mux

/* File: verif/control_pin_host.sv */
// Host-side model that drives the three control input pins of the relay switch.
module control_pin_host (
	input wire logic clk_in,
	input wire logic [2:0] level_in,
	input wire logic [2:0] open_in,
	output logic [2:0] pin_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Pin drive.
	// Pins start low so the design never sees an unknown level.
	initial pin_out = 3'h0;

	// A released pin falls to the pull-down level, never to its last value.
	always @(posedge clk_in) begin
		pin_out <= level_in & ~open_in;
	end
endmodule // control_pin_host

/* File: verif/power_mode_reset_input_mux_tb.sv */
// Self-checking testbench for the power mode, reset and input multiplexer block.
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end

module power_mode_reset_input_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WAKE = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic bat_ok = 1'b1;
	logic log_ok = 1'b1;
	logic [2:0] level = 3'h0;
	logic [2:0] open_pin = 3'h0;
	logic [2:0] pins;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [7:0] chan;
	logic op_mode;
	logic irq;
	int n_mismatch = 0;
	int checks = 0;
	int sel;
	int alt;

	// ==========================================================
	// Clock, partner and design.
	always #5 clk = ~clk;

	control_pin_host host (.clk_in(clk), .level_in(level), .open_in(open_pin), .pin_out(pins));

	power_mode_reset_input_mux #(.WAKE_TIME_CYCLES(WAKE)) DUT (
		.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .BATTERY_SUPPLY_OK_IN(bat_ok),
		.LOGIC_SUPPLY_OK_IN(log_ok), .INPUT_PIN_FIRST_IN(pins[0]), .INPUT_PIN_SECOND_IN(pins[1]),
		.INPUT_PIN_THIRD_IN(pins[2]), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WRITE_IN(wr),
		.REG_READ_IN(rd), .REG_RDATA_OUT(rdata), .CHANNEL_OUT(chan), .OPERATION_MODE_OUT(op_mode),
		.IRQ_OUT(irq));

	// ==========================================================
	// Reference model of the channel multiplexer, worked from integers.
	function automatic logic [7:0] exp_chan(input int s, input int a, input int p);
		logic [7:0] r;
		r = 8'h00;
		for (int ch = 0; ch < 8; ch++) begin
			case ((s >> (2 * ch)) & 3)
				1: r[ch] = p[0];
				2: r[ch] = a[ch] ? p[2] : p[1];
				3: r[ch] = 1'b1;
				default: r[ch] = 1'b0;
			endcase
		end
		return r;
	endfunction

	// ==========================================================
	// Register bus tasks; the master holds each strobe for exactly one cycle.
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are sampled there.
	task automatic reg_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(nm, e, rdata)
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Wake and watch the mode output rise exactly when the wake time runs out.
	task automatic wake_up();
		reg_wr(8'h00, 32'h0000_0001);
		reg_chk(8'h04, 32'h0000_0008, "status waking");
		settle(WAKE - 2);
		`CHK("mode early", 1'b0, op_mode)
		settle(1);
		`CHK("mode awake", 1'b1, op_mode)
	endtask

	task automatic finish_test();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================
	// Watchdog: the tests need well under two thousand cycles.
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end

	// ==========================================================
	// Main sequence.
	initial begin
		void'($urandom(32'haeb9_036c));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		settle(4);
		// Power-up: sleep, defaults, error flag raised and cleared by reading.
		`CHK("mode reset", 1'b0, op_mode)
		reg_chk(8'h04, 32'h0000_0002, "status reset");
		reg_chk(8'h04, 32'h0000_0000, "status clear");
		reg_chk(8'h08, 32'h0000_0000, "select reset");
		reg_chk(8'h10, 32'h0000_0001, "irq reset");
		reg_chk(8'h1C, 32'h0000_0000, "unmapped");
		// Wake with the awake event unmasked, then clear it by reading.
		reg_wr(8'h14, 32'h0000_0002);
		wake_up();
		`CHK("irq raised", 1'b1, irq)
		reg_chk(8'h00, 32'h0000_0000, "command read");
		reg_chk(8'h10, 32'h0000_0002, "irq awake");
		settle(2);
		`CHK("irq cleared", 1'b0, irq)
		// Random per-channel sources and pin levels.
		for (int i = 0; i < 8; i++) begin
			sel = $urandom & 16'hFFFF;
			alt = $urandom & 8'hFF;
			reg_wr(8'h08, sel);
			reg_wr(8'h0C, alt);
			@(posedge clk);
			level <= 3'($urandom);
			settle(6);
			`CHK("channels", exp_chan(sel, alt, int'(level)), chan)
			reg_chk(8'h08, 32'(sel), "select back");
			reg_chk(8'h0C, 32'(alt), "alt back");
		end
		// Open pins read low; channels that follow them go off.
		reg_wr(8'h08, 32'h0000_9559);
		reg_wr(8'h0C, 32'h0000_00F0);
		@(posedge clk);
		level <= 3'h7;
		open_pin <= 3'h7;
		settle(6);
		`CHK("open pins", exp_chan(16'h9559, 8'hF0, 0), chan)
		@(posedge clk);
		open_pin <= 3'h0;
		// Standby returns to sleep and clears the select and pin banks, not the mask, without the error flag.
		reg_wr(8'h00, 32'h0000_0002);
		settle(2);
		`CHK("standby mode", 1'b0, op_mode)
		`CHK("standby chan", 8'h00, chan)
		reg_chk(8'h08, 32'h0000_0000, "standby select");
		reg_chk(8'h04, 32'h0000_0000, "standby status");
		// Reset command in operation with all channels forced on.
		wake_up();
		reg_wr(8'h14, 32'h0000_0007);
		reg_wr(8'h08, 32'h0000_FFFF);
		settle(3);
		`CHK("all on", 8'hFF, chan)
		reg_wr(8'h00, 32'h0000_0004);
		settle(2);
		`CHK("reset chan", 8'h00, chan)
		`CHK("reset mode", 1'b0, op_mode)
		`CHK("reset irq", 1'b0, irq)
		reg_chk(8'h14, 32'h0000_0000, "reset mask");
		reg_chk(8'h08, 32'h0000_0000, "reset select");
		reg_chk(8'h04, 32'h0000_0002, "reset status");
		// Battery undervoltage: frame on reads, writes ignored, release only when good.
		wake_up();
		@(posedge clk);
		bat_ok <= 1'b0;
		settle(4);
		`CHK("uv mode", 1'b0, op_mode)
		reg_chk(8'h04, power_mode_pkg::DIAG_FRAME, "uv frame");
		reg_wr(8'h08, 32'h0000_FFFF);
		reg_chk(8'h08, power_mode_pkg::DIAG_FRAME, "uv select");
		@(posedge clk);
		bat_ok <= 1'b1;
		settle(4);
		reg_chk(8'h08, 32'h0000_0000, "uv select after");
		reg_chk(8'h04, 32'h0000_0002, "uv status after");
		reg_chk(8'h10, 32'h0000_0007, "uv irq");
		// Logic supply off forces sleep.
		wake_up();
		@(posedge clk);
		log_ok <= 1'b0;
		settle(4);
		`CHK("logic off mode", 1'b0, op_mode)
		`CHK("logic off chan", 8'h00, chan)
		@(posedge clk);
		log_ok <= 1'b1;
		settle(4);
		reg_chk(8'h04, 32'h0000_0002, "logic on status");
		finish_test();
	end
endmodule // power_mode_reset_input_mux_tb
